/* File: hdl/nvmac_pkg.sv */
// constants and types of the nvm access control block
// assumes a 32-bit apb slave decoding the low address byte
package nvmac_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_UNLOCK  = 8'h04;
    localparam logic [7:0] OFF_ADDR_LO = 8'h08;
    localparam logic [7:0] OFF_ADDR_HI = 8'h0C;
    localparam logic [7:0] OFF_DATA_LO = 8'h10;
    localparam logic [7:0] OFF_DATA_HI = 8'h14;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;
    // control bit positions
    localparam int B_RD = 0, B_WR = 1, B_PROGRAM_ENABLE = 2, B_WERR = 3;
    localparam int B_FREE = 4, B_LATCH_LOAD_ONLY = 5, B_CONFIG_SPACE_SELECT = 6, B_PGD = 7;
    // interrupt bits
    localparam int IRQ_DONE = 0, IRQ_ERR = 1, IRQ_W = 2;
    // unlock pattern
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // word geometry
    localparam int AW = 15, DW = 14, IDX_W = 3, LATCHES = 8;
    localparam int CNT_W = 4, TIMER_W = 24;
    // reachable part of configuration space
    localparam logic [AW-1:0] CFG_UID_LAST = 15'h0003;
    localparam logic [AW-1:0] CFG_DEVID    = 15'h0006;
    localparam logic [AW-1:0] CFG_LAST     = 15'h0008;
    // self-timed durations, plain defaults
    localparam int CLK_MHZ = 40;
    localparam int ERASE_US = 2000, PROG_US = 2000, EE_US = 4000;
    typedef enum logic [1:0] {SP_EEPROM, SP_PROGRAM, SP_CONFIG}
        nvmac_space_t;
    typedef enum {ST_IDLE, ST_STREAM, ST_WAIT} nvmac_state_t;
    typedef enum {KEY_IDLE, KEY_HALF, KEY_ARMED} nvmac_key_t;
    // configuration select overrides the program select
    function automatic nvmac_space_t space_of(logic config_space_select, logic pgd);
        return config_space_select ? SP_CONFIG : (pgd ? SP_PROGRAM : SP_EEPROM);
    endfunction
    function automatic logic cfg_readable(logic [AW-1:0] a);
        return (a <= CFG_UID_LAST) || (a >= CFG_DEVID && a <= CFG_LAST);
    endfunction
    function automatic logic cfg_writable(logic [AW-1:0] a);
        return a <= CFG_UID_LAST;
    endfunction
endpackage

/* File: hdl/nvmac_latch_if.sv */
// write-latch port between the controller and the latch memory
// assumes both ends on the same clock
interface nvmac_latch_if #(parameter int W = 14, parameter int IW = 3);
    logic          wr_en;
    logic [IW-1:0] wr_idx;
    logic [W-1:0]  wr_data;
    logic          rd_en;
    logic [IW-1:0] rd_idx;
    logic [W-1:0]  rd_data;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  input rd_data);
    modport mem (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 output rd_data);
endinterface

/* File: hdl/nvmac_latch_mem.sv */
// flash write latches: small memory with registered read data
// assumes one write and one read port on pclk
module nvmac_latch_mem #(
    parameter int W     = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input logic         pclk,
    input logic         presetn,
    // latch port
    nvmac_latch_if.mem  lp
);
    initial if (DEPTH < 2 || W < 1) $error("nvmac_latch_mem: bad size");

    logic [W-1:0] cell_reg [DEPTH];

    // latches are cleared at reset only, so a partial row programs zeros until the first program
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) cell_reg[i] <= '0;
        end else if (lp.wr_en) begin
            cell_reg[lp.wr_idx] <= lp.wr_data;
        end
    end

    // read data held in a register, one cycle after rd_en
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lp.rd_data <= '0;
        else if (lp.rd_en) lp.rd_data <= cell_reg[lp.rd_idx];
    end
endmodule // nvmac_latch_mem

/* File: hdl/nvmac_unlock.sv */
// unlock key decoder: no storage, only a tracker of the pattern
// assumes acc_stb marks every completed bus access
module nvmac_unlock
    import nvmac_pkg::*;
(
    // clock and reset
    input  logic       pclk,
    input  logic       presetn,
    // bus events
    input  logic       acc_stb,
    input  logic       key_wr,
    input  logic [7:0] key_data,
    // arm state
    output logic       armed
);
    nvmac_key_t key_reg, key_next;
    logic       is_first, is_second;

    // pattern must arrive as consecutive accesses, nothing between
    assign is_first  = key_wr && key_data == KEY_FIRST;
    assign is_second = key_wr && key_data == KEY_SECOND;
    assign armed     = key_reg == KEY_ARMED;

    // any access that breaks the pattern drops the arm
    always_comb begin
        key_next = key_reg;
        if (acc_stb) begin
            unique case (key_reg)
                KEY_IDLE:  key_next = is_first ? KEY_HALF : KEY_IDLE;
                KEY_HALF:  key_next = is_second ? KEY_ARMED :
                                      is_first ? KEY_HALF : KEY_IDLE;
                KEY_ARMED: key_next = is_first ? KEY_HALF : KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) key_reg <= KEY_IDLE;
        else key_reg <= key_next;
    end

    a_key_arms_pair: assert property (@(posedge pclk)
        disable iff (!presetn)
        key_reg == KEY_HALF && acc_stb && is_second |=> armed)
        else $error("second key after first did not arm");
endmodule // nvmac_unlock

/* File: hdl/nvmac_top.sv */
// nvm access control: apb registers, unlock, erase/write sequencer
// assumes an nvm array on pclk: read data valid in the strobe cycle
// What this block does
// - erase bit makes next flash start erase row
// - error flag set on every start attempt but a latch load
// - no program/erase while enable is clear
// - start bit set-only, cleared by hardware
// - unlock key is write-only decode, unstored
// - key writes only recognise consecutive pattern
// - bad config read clears data pair
// - processor stalls until erase/write completes
// - flash writes gather in eight latches
//
// Implementation choices: register access over APB and the register addresses.
module nvmac_top
    import nvmac_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_US * CLK_MHZ,
    parameter int PROG_CYC  = PROG_US * CLK_MHZ,
    parameter int EE_CYC    = EE_US * CLK_MHZ
) (
    // clock and reset
    input  logic          pclk,
    input  logic          presetn,
    // apb slave
    input  logic          psel,
    input  logic          penable,
    input  logic          pwrite,
    input  logic [7:0]    paddr,
    input  logic [31:0]   pwdata,
    output logic [31:0]   prdata,
    output logic          pready,
    output logic          pslverr,
    // nvm array port
    output nvmac_space_t  mem_space,
    output logic [AW-1:0] mem_addr,
    output logic [DW-1:0] mem_wdata,
    output logic          mem_rd_stb,
    output logic          mem_wr_stb,
    output logic          mem_erase_stb,
    input  logic [DW-1:0] mem_rdata,
    // core side
    output logic          cpu_stall,
    output logic          irq
);
    initial begin
        if (ERASE_CYC < 2 || ERASE_CYC >= 2**TIMER_W)
            $error("nvmac_top: ERASE_CYC out of range");
        if (PROG_CYC < 2 || PROG_CYC >= 2**TIMER_W)
            $error("nvmac_top: PROG_CYC out of range");
        if (EE_CYC < 2 || EE_CYC >= 2**TIMER_W)
            $error("nvmac_top: EE_CYC out of range");
    end

    nvmac_latch_if #(.W(DW), .IW(IDX_W)) lat ();

    // state
    nvmac_state_t  state_reg, state_next;
    nvmac_space_t  cur_space, mem_space_reg;
    logic [CNT_W-1:0]   cnt_reg, cnt_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic          op_erase_reg, op_erase_next;
    logic          pgd_reg, config_space_select_reg, latch_load_only_reg, free_reg;
    logic          werr_reg, program_enable_reg, wr_reg, rd_reg;
    logic          pgd_next, config_space_select_next, latch_load_only_next, free_next;
    logic          werr_next, program_enable_next, wr_next, rd_next;
    logic [AW-1:0] addr_reg, addr_next, mem_addr_reg, mem_addr_next;
    logic [DW-1:0] data_reg, data_next, mem_wd_reg, mem_wd_next;
    logic          mem_wr_reg, mem_er_reg;
    logic [IRQ_W-1:0] ist_reg, ist_next, imsk_reg, imsk_next;
    logic [IRQ_W-1:0] ist_set, ist_clr;
    logic [31:0]   prdata_reg;
    logic [7:0]    ctrl_byte, rd_byte;

    // bus decode
    logic acc_setup, acc_stb, wr_stb, mapped, is_idle, key_armed;
    logic hit_ctrl, hit_key, hit_alo, hit_ahi, hit_dlo, hit_dhi;
    logic hit_ist, hit_imsk, ctrl_wr, ctrl_sw, wr_try, rd_try;
    logic flash_side, target_ok, start_op, start_latch, start_erase;
    logic start_prog, start_ee, timer_end, op_done, bad_cfg_read;
    logic stream_wr;

    // zero-wait slave: read data captured in the setup cycle
    assign acc_setup = psel && !penable;
    assign acc_stb   = psel && penable;
    assign wr_stb    = acc_stb && pwrite;
    assign pready    = penable;
    assign hit_ctrl  = paddr == OFF_CONTROL;
    assign hit_key   = paddr == OFF_UNLOCK;
    assign hit_alo   = paddr == OFF_ADDR_LO;
    assign hit_ahi   = paddr == OFF_ADDR_HI;
    assign hit_dlo   = paddr == OFF_DATA_LO;
    assign hit_dhi   = paddr == OFF_DATA_HI;
    assign hit_ist   = paddr == OFF_IRQ_ST;
    assign hit_imsk  = paddr == OFF_IRQ_MSK;
    assign mapped    = hit_ctrl | hit_key | hit_alo | hit_ahi |
                       hit_dlo | hit_dhi | hit_ist | hit_imsk;
    assign pslverr   = acc_stb && !mapped;

    // key register is only a decoder input, nothing stored
    nvmac_unlock u_unlock (
        .pclk     (pclk),
        .presetn  (presetn),
        .acc_stb  (acc_stb),
        .key_wr   (wr_stb && hit_key),
        .key_data (pwdata[7:0]),
        .armed    (key_armed)
    );

    nvmac_latch_mem #(.W(DW), .DEPTH(LATCHES)) u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .lp      (lat)
    );

    // start conditions
    assign is_idle     = state_reg == ST_IDLE;
    assign ctrl_wr     = wr_stb && hit_ctrl;
    assign ctrl_sw     = ctrl_wr && is_idle;
    assign wr_try      = ctrl_wr && pwdata[B_WR];
    assign rd_try      = ctrl_sw && pwdata[B_RD] && !rd_reg;
    assign cur_space   = space_of(config_space_select_reg, pgd_reg);
    assign flash_side  = cur_space != SP_EEPROM;
    assign target_ok   = cur_space != SP_CONFIG || cfg_writable(addr_reg);
    // write starts only after the unlock pair and with enable set
    assign start_op    = wr_try && key_armed && program_enable_reg
                         && is_idle && !rd_reg && target_ok;
    assign start_latch = start_op && flash_side && latch_load_only_reg
                         && !free_reg;
    assign start_erase = start_op && flash_side && free_reg;
    assign start_prog  = start_op && flash_side && !latch_load_only_reg
                         && !free_reg;
    assign start_ee    = start_op && !flash_side;
    assign timer_end   = state_reg == ST_WAIT && timer_reg == '0;
    assign op_done     = timer_end || start_latch;
    assign bad_cfg_read = cur_space == SP_CONFIG && !cfg_readable(addr_reg);
    assign stream_wr   = state_reg == ST_STREAM && cnt_reg != '0;

    // control bits; field writes are ignored while an operation runs
    assign pgd_next  = ctrl_sw ? pwdata[B_PGD] : pgd_reg;
    assign config_space_select_next = ctrl_sw ? pwdata[B_CONFIG_SPACE_SELECT] : config_space_select_reg;
    assign latch_load_only_next = ctrl_sw ? pwdata[B_LATCH_LOAD_ONLY] : latch_load_only_reg;
    assign program_enable_next = ctrl_sw ? pwdata[B_PROGRAM_ENABLE] : program_enable_reg;
    assign free_next = (timer_end && op_erase_reg) ? 1'b0 :
                       ctrl_sw ? pwdata[B_FREE] : free_reg;
    // every set attempt flags and wins over a completion in the same
    // cycle; only a latch load clears together with its own attempt
    assign werr_next = (wr_try && !start_latch) ? 1'b1 :
                       op_done ? 1'b0 :
                       ctrl_sw ? pwdata[B_WERR] : werr_reg;
    // start bit: software can set it, only the sequencer clears it
    assign wr_next   = (start_op && !start_latch) ? 1'b1 :
                       timer_end ? 1'b0 : wr_reg;
    assign rd_next   = rd_try;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pgd_reg, config_space_select_reg, latch_load_only_reg, free_reg} <= 4'h0;
            {werr_reg, program_enable_reg, wr_reg, rd_reg}    <= 4'h0;
        end else begin
            {pgd_reg, config_space_select_reg, latch_load_only_reg, free_reg} <=
                {pgd_next, config_space_select_next, latch_load_only_next, free_next};
            {werr_reg, program_enable_reg, wr_reg, rd_reg} <=
                {werr_next, program_enable_next, wr_next, rd_next};
        end
    end

    // address and data holding; a read result beats a bus write
    assign addr_next = !(is_idle && wr_stb) ? addr_reg :
                       hit_alo ? {addr_reg[AW-1:8], pwdata[7:0]} :
                       hit_ahi ? {pwdata[AW-9:0], addr_reg[7:0]} : addr_reg;
    assign data_next = rd_reg ? (bad_cfg_read ? '0 : mem_rdata) :
                       !(is_idle && wr_stb) ? data_reg :
                       hit_dlo ? {data_reg[DW-1:8], pwdata[7:0]} :
                       hit_dhi ? {pwdata[DW-9:0], data_reg[7:0]} : data_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= '0;
            data_reg <= '0;
        end else begin
            addr_reg <= addr_next;
            data_reg <= data_next;
        end
    end

    // latch port: each flash latch-only or program start loads the addressed latch, then a
    // program start streams all eight out in order
    assign lat.wr_en   = start_op && flash_side && !free_reg;
    assign lat.wr_idx  = addr_reg[IDX_W-1:0];
    assign lat.wr_data = data_reg;
    assign lat.rd_en   = state_reg == ST_STREAM && cnt_reg < CNT_W'(LATCHES);
    assign lat.rd_idx  = cnt_reg[IDX_W-1:0];

    // sequencer
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        timer_next    = timer_reg;
        op_erase_next = op_erase_reg;
        unique case (state_reg)
            ST_IDLE: begin
                cnt_next = '0;
                if (start_prog) begin
                    state_next = ST_STREAM;
                end else if (start_erase) begin
                    state_next    = ST_WAIT;
                    op_erase_next = 1'b1;
                    timer_next    = TIMER_W'(ERASE_CYC - 1);
                end else if (start_ee) begin
                    state_next    = ST_WAIT;
                    op_erase_next = 1'b0;
                    timer_next    = TIMER_W'(EE_CYC - 1);
                end
            end
            ST_STREAM: begin
                if (cnt_reg == CNT_W'(LATCHES)) begin
                    state_next    = ST_WAIT;
                    op_erase_next = 1'b0;
                    timer_next    = TIMER_W'(PROG_CYC - 1);
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_WAIT: begin
                if (timer_reg == '0) state_next = ST_IDLE;
                else timer_next = timer_reg - 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= '0;
            timer_reg    <= '0;
            op_erase_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            timer_reg    <= timer_next;
            op_erase_reg <= op_erase_next;
        end
    end

    // array port follows the holding registers while idle so a read
    // strobe finds address and space already settled
    assign mem_addr_next = stream_wr ?
        {addr_reg[AW-1:IDX_W], IDX_W'(cnt_reg - 1'b1)} :
        is_idle ? addr_reg : mem_addr_reg;
    assign mem_wd_next = stream_wr ? lat.rd_data :
                         is_idle ? data_reg : mem_wd_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_space_reg <= SP_EEPROM;
            mem_addr_reg  <= '0;
            mem_wd_reg    <= '0;
            mem_wr_reg    <= 1'b0;
            mem_er_reg    <= 1'b0;
        end else begin
            if (is_idle) mem_space_reg <= space_of(config_space_select_next, pgd_next);
            mem_addr_reg <= mem_addr_next;
            mem_wd_reg   <= mem_wd_next;
            mem_wr_reg   <= start_ee || stream_wr;
            mem_er_reg   <= start_erase;
        end
    end

    assign mem_space     = mem_space_reg;
    assign mem_addr      = mem_addr_reg;
    assign mem_wdata     = mem_wd_reg;
    assign mem_wr_stb    = mem_wr_reg;
    assign mem_erase_stb = mem_er_reg;
    // unreachable config words are never fetched
    assign mem_rd_stb    = rd_reg && !bad_cfg_read;
    // core halts for the whole self-timed operation
    assign cpu_stall     = !is_idle;

    // sticky events, write one to clear; a new event wins the clear
    assign ist_set   = {wr_try && !start_op, op_done};
    assign ist_clr   = (wr_stb && hit_ist) ? pwdata[IRQ_W-1:0] : '0;
    assign ist_next  = (ist_reg & ~ist_clr) | ist_set;
    assign imsk_next = (wr_stb && hit_imsk) ? pwdata[IRQ_W-1:0] : imsk_reg;
    assign irq       = |(ist_reg & imsk_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_reg  <= '0;
            imsk_reg <= '0;
        end else begin
            ist_reg  <= ist_next;
            imsk_reg <= imsk_next;
        end
    end

    // read mux; unlock key and unused bits read as zero
    assign ctrl_byte = {pgd_reg, config_space_select_reg, latch_load_only_reg, free_reg,
                        werr_reg, program_enable_reg, wr_reg, rd_reg};
    assign rd_byte =
        hit_ctrl ? ctrl_byte :
        hit_alo  ? addr_reg[7:0] :
        hit_ahi  ? 8'(addr_reg[AW-1:8]) :
        hit_dlo  ? data_reg[7:0] :
        hit_dhi  ? 8'(data_reg[DW-1:8]) :
        hit_ist  ? 8'(ist_reg) :
        hit_imsk ? 8'(imsk_reg) : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_reg <= 32'h0000_0000;
        else if (acc_setup && !pwrite) prdata_reg <= {24'h00_0000, rd_byte};
    end
    assign prdata = prdata_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_erase_end;
        state_reg == ST_WAIT && op_erase_reg && timer_reg == '0;
    endsequence
    sequence s_burst;
        ##2 mem_wr_stb [*8] ##1 !mem_wr_stb;
    endsequence

    a_steer_program: assert property (mem_rd_stb && !config_space_select_reg |->
        mem_space == (pgd_reg ? SP_PROGRAM : SP_EEPROM))
        else $error("read not steered by program select");
    a_steer_config: assert property (
        mem_rd_stb && config_space_select_reg |-> mem_space == SP_CONFIG)
        else $error("config read went to wrong space");
    a_erase_free_clr: assert property (
        s_erase_end |=> !free_reg && !wr_reg)
        else $error("erase end left erase or start bit set");
    a_werr_on_try: assert property (
        wr_try && !start_op |=> werr_reg && ist_reg[IRQ_ERR])
        else $error("refused start did not flag error");
    a_enable_gates: assert property (wr_try && !program_enable_reg |=>
        !wr_reg && state_reg == ST_IDLE && !mem_wr_stb)
        else $error("start taken with enable clear");
    a_start_held: assert property (
        wr_reg && !timer_end |=> wr_reg)
        else $error("start bit dropped before completion");
    a_start_keyed: assert property (
        $rose(wr_reg) |-> $past(key_armed))
        else $error("start without unlock pattern");
    a_key_reads_zero: assert property (
        acc_setup && !pwrite && hit_key |=> prdata == 32'h0000_0000)
        else $error("unlock key read back nonzero");
    a_bad_cfg_clear: assert property (rd_reg && bad_cfg_read |->
        !mem_rd_stb ##1 data_reg == '0)
        else $error("bad config read did not clear data");
    a_stall_op: assert property (
        start_erase || start_ee |=> cpu_stall [*2])
        else $error("core not stalled during operation");
    a_stream_eight: assert property (
        $rose(state_reg == ST_STREAM) |-> s_burst)
        else $error("program burst is not eight words");
    a_latch_only: assert property (start_latch |=>
        !wr_reg && !cpu_stall && ist_reg[IRQ_DONE])
        else $error("latch-only start ran an operation");
    a_read_pulse: assert property (
        rd_try |=> rd_reg ##1 !rd_reg)
        else $error("read bit not one cycle");
    a_irq_done: assert property (
        op_done && imsk_reg[IRQ_DONE] && !ist_clr[IRQ_DONE] |=> irq)
        else $error("done event did not raise irq");
endmodule // nvmac_top

/* File: tb/tb.sv */
// self-checking bench for the nvm access control block
// assumes apb with zero wait states and short self-timed durations
module tb
    import nvmac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic          mem_rd_stb, mem_wr_stb, mem_erase_stb, cpu_stall, irq;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rnd;
    logic [AW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata, mem_rdata;
    nvmac_space_t  mem_space;
    logic [32:0]   exp_q[$];
    logic [7:0]    lat[LATCHES];
    int            err_count, tests_run, wr_cnt, er_cnt, n, rd_cnt, pg_idx;

    // short durations keep the run brief; 16 is above the minimum of 2
    nvmac_top #(.ERASE_CYC(16), .PROG_CYC(16), .EE_CYC(16)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_space(mem_space),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd_stb(mem_rd_stb), .mem_wr_stb(mem_wr_stb),
        .mem_erase_stb(mem_erase_stb), .mem_rdata(mem_rdata),
        .cpu_stall(cpu_stall), .irq(irq));

    always #12.5 pclk = ~pclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one apb transfer; a read notes its expected slverr and data
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin err_count++; final_report(); end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({a > OFF_IRQ_MSK, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // unlock pattern then a start; the bus carries nothing in between
    task automatic start(input logic [7:0] c);
        apb(1'b1, OFF_UNLOCK, {24'h0, KEY_FIRST});
        apb(1'b1, OFF_UNLOCK, {24'h0, KEY_SECOND});
        apb(1'b1, OFF_CONTROL, {24'h0, c});
        n = 0;
        do @(posedge pclk); while (cpu_stall !== 1'b0 && ++n < 400);
        if (n >= 400) begin err_count++; final_report(); end
    endtask

    // watcher: read results against the oldest note, strobes counted
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());
        if (mem_wr_stb) begin
            wr_cnt++;
            if (mem_space == SP_PROGRAM) begin
                check(33'(mem_wdata), 33'(lat[mem_addr[2:0]]));
                check(33'(mem_addr), 33'(pg_idx));
                pg_idx++;
            end
        end
        if (mem_rd_stb) rd_cnt++;
        if (mem_erase_stb) er_cnt++;
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; mem_rdata = 14'h0; rnd = 32'hf965_6f4c;
        err_count = 0; tests_run = 0; wr_cnt = 0; er_cnt = 0;
        rd_cnt = 0; pg_idx = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CONTROL, 32'h0);
        rd(OFF_UNLOCK, 32'h0);
        rd(8'h20, 32'h0);
        // random address written, high byte read back, then a one-cycle eeprom read
        rnd = lfsr(rnd);
        apb(1'b1, OFF_ADDR_LO, {24'h0, rnd[7:0]});
        apb(1'b1, OFF_ADDR_HI, {24'h0, 1'b0, rnd[14:8]});
        rd(OFF_ADDR_HI, {24'h0, 1'b0, rnd[14:8]});
        @(posedge pclk) mem_rdata <= rnd[21:8] | 14'h0001;
        apb(1'b1, OFF_CONTROL, 32'h01);
        rd(OFF_DATA_LO, {24'h0, rnd[15:8] | 8'h01});
        rd(OFF_DATA_HI, {26'h0, rnd[21:16]});
        rd(OFF_CONTROL, 32'h0);
        check(33'(rd_cnt), 33'd1);
        // unreachable configuration address clears the data pair
        apb(1'b1, OFF_ADDR_LO, 32'h05);
        apb(1'b1, OFF_ADDR_HI, 32'h00);
        apb(1'b1, OFF_CONTROL, 32'h41);
        rd(OFF_DATA_LO, 32'h0);
        rd(OFF_DATA_HI, 32'h0);
        check(33'(rd_cnt), 33'd1);
        // broken unlock pattern: start refused, error flag and event
        apb(1'b1, OFF_CONTROL, 32'h04);
        apb(1'b1, OFF_IRQ_ST, 32'h03);
        apb(1'b1, OFF_UNLOCK, {24'h0, KEY_FIRST});
        rd(OFF_IRQ_ST, 32'h0);
        apb(1'b1, OFF_UNLOCK, {24'h0, KEY_SECOND});
        apb(1'b1, OFF_CONTROL, 32'h06);
        rd(OFF_CONTROL, 32'h0C);
        rd(OFF_IRQ_ST, 32'h02);
        // enable clear: unlocked start must not program
        apb(1'b1, OFF_CONTROL, 32'h00);
        start(8'h02);
        check(33'(wr_cnt), 33'd0);
        // eeprom write, then interrupt raised, unmasked and cleared
        apb(1'b1, OFF_IRQ_ST, 32'h03);
        apb(1'b1, OFF_CONTROL, 32'h04);
        start(8'h06);
        check(33'(wr_cnt), 33'd1);
        rd(OFF_CONTROL, 32'h04);
        rd(OFF_IRQ_ST, 32'h01);
        check(33'(irq), 33'd0);
        apb(1'b1, OFF_IRQ_MSK, 32'h01);
        @(posedge pclk);
        check(33'(irq), 33'd1);
        apb(1'b1, OFF_IRQ_ST, 32'h01);
        @(posedge pclk);
        check(33'(irq), 33'd0);
        // row erase in program space clears the erase bit when done
        apb(1'b1, OFF_CONTROL, 32'h94);
        start(8'h96);
        check(33'(er_cnt), 33'd1);
        rd(OFF_CONTROL, 32'h84);
        // eight latch loads, then one program of the whole group
        apb(1'b1, OFF_CONTROL, 32'hA4);
        for (int i = 0; i < LATCHES; i++) begin
            rnd = lfsr(rnd);
            lat[i] = rnd[7:0];
            apb(1'b1, OFF_ADDR_LO, 32'(i));
            apb(1'b1, OFF_DATA_LO, {24'h0, rnd[7:0]});
            start(8'hA6);
        end
        check(33'(wr_cnt), 33'd1);
        apb(1'b1, OFF_CONTROL, 32'h84);
        start(8'h86);
        check(33'(wr_cnt), 33'd9);
        final_report();
    end
endmodule // tb
